// File: shared/adcreg_pkg.sv
// Purpose: Constants for the converter configuration register bank
// Assumes: 16-bit register addresses, 8-bit register data
// Notes: Offsets, field positions and reset values live here, except the power field and the DCS and chop resets
package adcreg_pkg;
	// Register offsets
	localparam logic [15:0] ADDR_PORT_CFG = 16'h0000;
	localparam logic [15:0] ADDR_CHIP_IDENTIFIER = 16'h0001;
	localparam logic [15:0] ADDR_GRADE = 16'h0002;
	localparam logic [15:0] ADDR_INDEX = 16'h0005;
	localparam logic [15:0] ADDR_LOCAL = 16'h0006;
	localparam logic [15:0] ADDR_POWER = 16'h0008;
	localparam logic [15:0] ADDR_DCS = 16'h0009;
	localparam logic [15:0] ADDR_DIV = 16'h000B;
	localparam logic [15:0] ADDR_CHOP = 16'h000C;
	localparam logic [15:0] ADDR_COMMIT = 16'h00FF;
	// Values after reset
	localparam logic [7:0] RST_PORT_CFG = 8'h18;
	localparam logic [7:0] RST_INDEX = 8'h33;
	localparam logic [7:0] RST_LOCAL = 8'h00;
	localparam logic [1:0] RST_POWER = 2'h0;
	localparam logic [2:0] RST_DIV = 3'h0;
	// Port configuration field positions (mirrored nibbles)
	localparam int PC_SDO_HI = 7;
	localparam int PC_LSB_HI = 6;
	localparam int PC_SRST_HI = 5;
	localparam int PC_A16_HI = 4;
	localparam int PC_A16_LO = 3;
	localparam int PC_SRST_LO = 2;
	localparam int PC_LSB_LO = 1;
	localparam int PC_SDO_LO = 0;
	// Index bits: data A, data B, frame clock, data clock
	localparam int NCH = 4;
	localparam int IDX_BIT [NCH] = '{0, 1, 4, 5};
	// Other field positions
	localparam int DCS_BIT = 0;
	localparam int CHOP_BIT = 2;
	localparam int COMMIT_BIT = 0;
	localparam int DIV_W = 3;
	// Power modes
	typedef enum logic [1:0] {
		PM_RUN = 2'b00,
		PM_DOWN = 2'b01,
		PM_STBY = 2'b10,
		PM_RESET = 2'b11
	} adcreg_pmode_t;
endpackage

// File: hw/adcreg_bank.sv
// Purpose: Configuration register bank of a dual-channel converter
// Assumes: A serial framer delivers decoded register reads and writes
// Notes: Local registers have four copies steered by the index register
// Summary of operation
// - Every reset, hard or soft, loads each register with its default value.
// - Local registers have one physical copy per channel.
// - Index bits 0, 1, 4 and 5 pick data A, data B, frame clock and data clock copies.
// - With all index bits set a single write updates all four local copies.
// - A local read with all index bits set returns channel A's copy.
// - Global registers are never gated by the index register.
// - Port configuration bits 0 and 7 read zero and bits 3 and 4 read one.
// - Writing a soft reset bit resets all user registers and the bit self-clears.
// - Power mode field selects run, full power-down, standby or reset.
`timescale 1ns/10ps
module adcreg_bank
	import adcreg_pkg::*;
#(
	parameter logic [7:0] CHIP_IDENTIFIER = 8'h5A, // Arbitrary value
	parameter logic [2:0] GRADE_ID = 3'h1 // Arbitrary value
) (
	input wire logic mclk, // Converter clock
	input wire logic rstn, // Async reset, active low
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	input wire logic [15:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data
	output logic reg_rvalid, // Read data valid pulse
	output logic lsb_first, // Serial bit order LSB first
	output logic soft_reset, // Soft reset pulse
	output logic [1:0] power_mode, // Operating state
	output logic dcs_on, // Duty cycle stabiliser on
	output logic chop_on, // Chop mode on
	output logic [2:0] clk_div, // Divide ratio minus one
	output logic clk_div_tick, // Divided sample clock tick
	output logic override_commit, // Override transfer pulse
	output logic [7:0] local_cfg_a, // Data channel A copy
	output logic [7:0] local_cfg_b, // Data channel B copy
	output logic [7:0] local_cfg_fco, // Frame clock output copy
	output logic [7:0] local_cfg_dco // Data clock output copy
);

	logic rst_s1_r;
	logic rst_n_r;
	logic srst_r;
	logic lsb_r;
	logic [7:0] index_r;
	logic [7:0] loc_r [NCH];
	logic [2:0] div_cnt_r;
	logic [7:0] rd_nxt;
	logic [7:0] port_val;
	logic wr_ok;

	// Reset release through two flops
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// Writes are dropped during the soft reset cycle
	assign wr_ok = reg_wr && !srst_r;

	// Soft reset request from either mirrored bit
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			srst_r <= 1'b0;
		end else begin
			srst_r <= wr_ok && (reg_addr == ADDR_PORT_CFG)
				&& (reg_wdata[PC_SRST_HI] || reg_wdata[PC_SRST_LO]);
		end
	end
	assign soft_reset = srst_r;

	// Port configuration: bit order from either nibble
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			lsb_r <= RST_PORT_CFG[PC_LSB_LO];
		end else if (srst_r) begin
			lsb_r <= RST_PORT_CFG[PC_LSB_LO];
		end else if (wr_ok && reg_addr == ADDR_PORT_CFG) begin
			lsb_r <= reg_wdata[PC_LSB_HI] || reg_wdata[PC_LSB_LO];
		end
	end
	assign lsb_first = lsb_r;

	// Mirrored readback; 3-wire and 16-bit address bits fixed
	always_comb begin
		port_val = 8'h00;
		port_val[PC_SDO_HI] = 1'b0;
		port_val[PC_SDO_LO] = 1'b0;
		port_val[PC_A16_HI] = 1'b1;
		port_val[PC_A16_LO] = 1'b1;
		port_val[PC_LSB_HI] = lsb_r;
		port_val[PC_LSB_LO] = lsb_r;
		port_val[PC_SRST_HI] = srst_r;
		port_val[PC_SRST_LO] = srst_r;
	end

	// Channel index register
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			index_r <= RST_INDEX;
		end else if (srst_r) begin
			index_r <= RST_INDEX;
		end else if (wr_ok && reg_addr == ADDR_INDEX) begin
			index_r <= reg_wdata & RST_INDEX;
		end
	end

	// Global function registers, never gated by the index
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			power_mode <= RST_POWER;
			dcs_on <= 1'b0;
			chop_on <= 1'b0;
			clk_div <= RST_DIV;
		end else if (srst_r) begin
			power_mode <= RST_POWER;
			dcs_on <= 1'b0;
			chop_on <= 1'b0;
			clk_div <= RST_DIV;
		end else if (wr_ok) begin
			case (reg_addr)
				ADDR_POWER: power_mode <= reg_wdata[1:0];
				ADDR_DCS: dcs_on <= reg_wdata[DCS_BIT];
				ADDR_CHOP: chop_on <= reg_wdata[CHOP_BIT];
				ADDR_DIV: clk_div <= reg_wdata[DIV_W-1:0];
				default: ;
			endcase
		end
	end

	// Transfer bit acts as a self-clearing pulse
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			override_commit <= 1'b0;
		end else begin
			override_commit <= wr_ok && (reg_addr == ADDR_COMMIT) && reg_wdata[COMMIT_BIT];
		end
	end

	// Sample clock divider: one tick every clk_div+1 cycles
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			div_cnt_r <= 3'h0;
			clk_div_tick <= 1'b0;
		end else if (div_cnt_r >= clk_div) begin
			div_cnt_r <= 3'h0;
			clk_div_tick <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 3'h1;
			clk_div_tick <= 1'b0;
		end
	end

	// One local copy per channel, written when its index bit is set
	for (genvar i = 0; i < NCH; i++) begin : g_loc
		always_ff @(posedge mclk or negedge rst_n_r) begin
			if (!rst_n_r) begin
				loc_r[i] <= RST_LOCAL;
			end else if (srst_r) begin
				loc_r[i] <= RST_LOCAL;
			end else if (wr_ok && reg_addr == ADDR_LOCAL && index_r[IDX_BIT[i]]) begin
				loc_r[i] <= reg_wdata;
			end
		end
	end
	assign local_cfg_a = loc_r[0];
	assign local_cfg_b = loc_r[1];
	assign local_cfg_fco = loc_r[2];
	assign local_cfg_dco = loc_r[3];

	// Read multiplexer; local reads prefer channel A
	always_comb begin
		rd_nxt = 8'h00;
		case (reg_addr)
			ADDR_PORT_CFG: rd_nxt = port_val;
			ADDR_CHIP_IDENTIFIER: rd_nxt = CHIP_IDENTIFIER;
			ADDR_GRADE: rd_nxt = {1'b0, GRADE_ID, 4'h0};
			ADDR_INDEX: rd_nxt = index_r;
			ADDR_POWER: rd_nxt = {6'h00, power_mode};
			ADDR_DCS: rd_nxt = {7'h00, dcs_on};
			ADDR_DIV: rd_nxt = {5'h00, clk_div};
			ADDR_CHOP: rd_nxt = {5'h00, chop_on, 2'h0};
			ADDR_COMMIT: rd_nxt = 8'h00;
			ADDR_LOCAL: begin
				if (index_r[IDX_BIT[0]]) begin
					rd_nxt = loc_r[0];
				end else if (index_r[IDX_BIT[1]]) begin
					rd_nxt = loc_r[1];
				end else if (index_r[IDX_BIT[2]]) begin
					rd_nxt = loc_r[2];
				end else if (index_r[IDX_BIT[3]]) begin
					rd_nxt = loc_r[3];
				end
			end
			default: rd_nxt = 8'h00;
		endcase
	end

	// Registered read answer
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rd_nxt;
			end
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n_r);

	// Soft reset from either nibble
	soft_clear_a: assert property (srst_r |=> !srst_r && !port_val[PC_SRST_HI])
		else $error("soft reset bit did not clear");
	soft_default_a: assert property (srst_r |=> index_r == RST_INDEX
		&& power_mode == RST_POWER && !dcs_on && !chop_on && clk_div == RST_DIV
		&& loc_r[0] == RST_LOCAL)
		else $error("defaults not restored by soft reset");
	soft_low_a: assert property (wr_ok && reg_addr == ADDR_PORT_CFG
		&& reg_wdata[PC_SRST_LO] |=> srst_r
		##1 !srst_r && lsb_r == RST_PORT_CFG[PC_LSB_LO] && loc_r[3] == RST_LOCAL)
		else $error("low nibble soft reset not taken");

	// Port configuration fixed bits and mirroring
	port_fixed_a: assert property (reg_rd && reg_addr == ADDR_PORT_CFG |=>
		!reg_rdata[PC_SDO_HI] && !reg_rdata[PC_SDO_LO]
		&& reg_rdata[PC_A16_HI] && reg_rdata[PC_A16_LO])
		else $error("port configuration fixed bits wrong");
	port_mirror_a: assert property (wr_ok && reg_addr == ADDR_PORT_CFG |=>
		port_val[PC_LSB_HI] == port_val[PC_LSB_LO]
		&& lsb_r == $past(reg_wdata[PC_LSB_HI] || reg_wdata[PC_LSB_LO]))
		else $error("port configuration nibbles not mirrored");
	port_read_a: assert property (reg_rd && reg_addr == ADDR_PORT_CFG |=>
		reg_rdata[PC_LSB_HI] == reg_rdata[PC_LSB_LO]
		&& reg_rdata[PC_SRST_HI] == reg_rdata[PC_SRST_LO])
		else $error("port configuration readback not mirrored");

	// Channel index and local copies
	index_mask_a: assert property (wr_ok && reg_addr == ADDR_INDEX |=>
		(index_r & ~RST_INDEX) == 8'h00
		&& index_r[IDX_BIT[3]] == $past(reg_wdata[IDX_BIT[3]]))
		else $error("index register kept an open bit");
	local_bcast_a: assert property (wr_ok && reg_addr == ADDR_LOCAL && index_r == RST_INDEX
		|=> loc_r[0] == $past(reg_wdata) && loc_r[1] == $past(reg_wdata)
		&& loc_r[2] == $past(reg_wdata) && loc_r[3] == $past(reg_wdata))
		else $error("broadcast write missed a copy");
	local_gate_a: assert property (wr_ok && reg_addr == ADDR_LOCAL && !index_r[IDX_BIT[1]]
		|=> $stable(loc_r[1]))
		else $error("unselected local copy changed");
	local_keep_a: assert property (wr_ok && reg_addr == ADDR_LOCAL && !index_r[IDX_BIT[0]]
		|=> $stable(loc_r[0]))
		else $error("channel A copy changed while unselected");
	local_clk_a: assert property (wr_ok && reg_addr == ADDR_LOCAL
		&& !index_r[IDX_BIT[2]] && !index_r[IDX_BIT[3]]
		|=> $stable(loc_r[2]) && $stable(loc_r[3]))
		else $error("clock output copy changed while unselected");
	local_take_a: assert property (wr_ok && reg_addr == ADDR_LOCAL && index_r[IDX_BIT[3]]
		|=> loc_r[3] == $past(reg_wdata))
		else $error("data clock copy missed its write");
	local_read_a: assert property (reg_rd && reg_addr == ADDR_LOCAL && index_r[IDX_BIT[0]]
		|=> reg_rdata == $past(loc_r[0]))
		else $error("local read did not return channel A");
	local_rdb_a: assert property (reg_rd && reg_addr == ADDR_LOCAL
		&& index_r[IDX_BIT[1]] && !index_r[IDX_BIT[0]]
		|=> reg_rdata == $past(loc_r[1]))
		else $error("local read did not return channel B");

	// Global registers
	global_wr_a: assert property (wr_ok && reg_addr == ADDR_DCS && index_r == 8'h00
		|=> dcs_on == $past(reg_wdata[DCS_BIT]))
		else $error("global write gated by index");
	chop_read_a: assert property (reg_rd && reg_addr == ADDR_CHOP
		|=> reg_rvalid && reg_rdata[CHOP_BIT] == $past(chop_on))
		else $error("chop enable readback wrong");
	pmode_set_a: assert property (wr_ok && reg_addr == ADDR_POWER
		|=> power_mode == $past(reg_wdata[1:0]))
		else $error("power mode not taken");
	dcs_set_a: assert property (wr_ok && reg_addr == ADDR_DCS
		|=> dcs_on == $past(reg_wdata[DCS_BIT]))
		else $error("stabiliser enable not taken");
	div_set_a: assert property (wr_ok && reg_addr == ADDR_DIV
		|=> clk_div == $past(reg_wdata[DIV_W-1:0]))
		else $error("clock divide field not taken");
	div_ratio_a: assert property (clk_div_tick && clk_div == 3'h3 && !reg_wr
		##1 !reg_wr [*2] |=> !clk_div_tick ##1 clk_div_tick)
		else $error("divide by four spacing wrong");
	chop_set_a: assert property (wr_ok && reg_addr == ADDR_CHOP
		|=> chop_on == $past(reg_wdata[CHOP_BIT]))
		else $error("chop enable not taken");

	soft_reset_c: cover property (srst_r);
	soft_low_c: cover property (wr_ok && reg_addr == ADDR_PORT_CFG
		&& reg_wdata[PC_SRST_LO] && !reg_wdata[PC_SRST_HI]);
	bcast_wr_c: cover property (wr_ok && reg_addr == ADDR_LOCAL && index_r == RST_INDEX);
	local_rd_c: cover property (reg_rd && reg_addr == ADDR_LOCAL && index_r[IDX_BIT[1]]
		&& !index_r[IDX_BIT[0]]);
	div_tick_c: cover property (clk_div_tick && clk_div == 3'h7);

endmodule // adcreg_bank

// File: test/adcreg_host.sv
// Purpose: Host model issuing decoded register accesses
// Assumes: Strobe taken at a rising edge, read answer one cycle later
// Notes: Idle address and data lines are inverted so stale values never match
`timescale 1ns/10ps
module adcreg_host (
	input wire logic mclk, // Converter clock
	output logic reg_wr, // Write strobe
	output logic reg_rd, // Read strobe
	output logic [15:0] reg_addr, // Address
	output logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic reg_rvalid // Read answer
);
	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h5A5A;
		reg_wdata = 8'hA5;
	end
	// One write of one byte, then release
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge mclk) #1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// One read; a missing answer gives unknown data
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk) #1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk) #1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
	endtask
endmodule // adcreg_host

// File: test/testbench.sv
// Purpose: Self-checking bench for the converter register bank
// Assumes: Host model drives the register port
// Notes: Identity parameters are set to values of our own
`timescale 1ns/10ps
module testbench;
	import adcreg_pkg::*;
	localparam logic [7:0] T_ID = 8'hC3; // Arbitrary value
	localparam logic [2:0] T_GRADE = 3'h2; // Arbitrary value
	logic mclk, rstn, reg_wr, reg_rd, reg_rvalid, lsb_first, soft_reset;
	logic dcs_on, chop_on, clk_div_tick, override_commit;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, la, lb, lf, ld, d;
	logic [1:0] power_mode;
	logic [2:0] clk_div;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	adcreg_bank #(.CHIP_IDENTIFIER(T_ID), .GRADE_ID(T_GRADE)) dut (.mclk(mclk), .rstn(rstn),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lsb_first(lsb_first),
		.soft_reset(soft_reset), .power_mode(power_mode), .dcs_on(dcs_on),
		.chop_on(chop_on), .clk_div(clk_div), .clk_div_tick(clk_div_tick),
		.override_commit(override_commit), .local_cfg_a(la), .local_cfg_b(lb),
		.local_cfg_fco(lf), .local_cfg_dco(ld));
	adcreg_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Hang ceiling
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk("rdata", e, d);
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic do_reset();
		rstn = 1'b0;
		repeat (16) @(posedge mclk);
		#1 rstn = 1'b1;
		repeat (3) @(posedge mclk);
	endtask
	task automatic t_defaults();
		logic [15:0] ad [9] = '{ADDR_PORT_CFG, ADDR_CHIP_IDENTIFIER, ADDR_GRADE, ADDR_INDEX,
			ADDR_POWER, ADDR_DCS, ADDR_DIV, ADDR_CHOP, ADDR_COMMIT};
		logic [7:0] ex [9] = '{RST_PORT_CFG, T_ID, {1'b0, T_GRADE, 4'h0}, RST_INDEX,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) begin
			rdc(ad[i], ex[i]);
		end
		chk("pins", 8'h00, {lsb_first, power_mode, dcs_on, chop_on, clk_div});
	endtask
	task automatic t_local();
		logic [7:0] sel [4] = '{8'h01, 8'h02, 8'h10, 8'h20};
		logic [7:0] val [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
		for (int i = 0; i < 4; i++) begin
			host.wr(ADDR_INDEX, sel[i]);
			host.wr(ADDR_LOCAL, val[i]);
		end
		chk("local_a", 8'hA5, la);
		chk("local_b", 8'h5A, lb);
		chk("local_fco", 8'h3C, lf);
		chk("local_dco", 8'hC3, ld);
		host.wr(ADDR_INDEX, 8'h02);
		rdc(ADDR_LOCAL, 8'h5A);
		host.wr(ADDR_INDEX, 8'hFF);
		rdc(ADDR_INDEX, 8'h33);
		host.wr(ADDR_LOCAL, 8'h77);
		chk("local_and", 8'h77, la & lb & lf & ld);
		chk("local_or", 8'h77, la | lb | lf | ld);
		host.wr(ADDR_INDEX, 8'h02);
		host.wr(ADDR_LOCAL, 8'h11);
		host.wr(ADDR_INDEX, 8'h33);
		rdc(ADDR_LOCAL, 8'h77);
	endtask
	task automatic t_global();
		int n;
		host.wr(ADDR_INDEX, 8'h00);
		for (int m = 0; m < 4; m++) begin
			host.wr(ADDR_POWER, 8'(m));
			chk("power_mode", 8'(m), {6'h00, power_mode});
		end
		host.wr(ADDR_DCS, 8'h01);
		host.wr(ADDR_CHOP, 8'h04);
		chk("dcs_chop", 8'h03, {6'h00, chop_on, dcs_on});
		rdc(ADDR_CHOP, 8'h04);
		// Tick count over 32 cycles for ratios 1, 2, 4, 8
		for (int k = 0; k < 4; k++) begin
			host.wr(ADDR_DIV, 8'((1 << k) - 1));
			chk("clk_div", 8'((1 << k) - 1), {5'h00, clk_div});
			repeat (8) @(posedge mclk);
			n = 0;
			repeat (32) begin
				@(posedge mclk) #1;
				n += int'(clk_div_tick);
			end
			chk("tick_count", 8'(32 >> k), 8'(n));
		end
		rdc(ADDR_DIV, 8'h07);
	endtask
	task automatic t_port();
		logic [7:0] wv [3] = '{8'h40, 8'h02, 8'h81};
		logic [7:0] rv [3] = '{8'h5A, 8'h5A, 8'h18};
		for (int i = 0; i < 3; i++) begin
			host.wr(ADDR_PORT_CFG, wv[i]);
			rdc(ADDR_PORT_CFG, rv[i]);
			chk("lsb_first", {7'h00, rv[i][6]}, {7'h00, lsb_first});
		end
		host.wr(ADDR_CHIP_IDENTIFIER, 8'h00);
		rdc(ADDR_CHIP_IDENTIFIER, T_ID);
		rdc(16'h0013, 8'h00);
		host.wr(ADDR_COMMIT, 8'h01);
		chk("commit", 8'h01, {7'h00, override_commit});
	endtask
	task automatic t_soft();
		logic [7:0] sv [2] = '{8'h20, 8'h04};
		for (int i = 0; i < 2; i++) begin
			host.wr(ADDR_POWER, 8'h01);
			host.wr(ADDR_INDEX, 8'h01);
			host.wr(ADDR_LOCAL, 8'h9C);
			host.wr(ADDR_PORT_CFG, sv[i] | 8'h42);
			chk("soft_reset", 8'h01, {7'h00, soft_reset});
			@(posedge mclk) #1;
			chk("after", 8'h00, {lsb_first, soft_reset, 4'h0, power_mode});
			chk("local_a", RST_LOCAL, la);
			rdc(ADDR_PORT_CFG, RST_PORT_CFG);
			rdc(ADDR_INDEX, RST_INDEX);
		end
	endtask
	// Main sequence
	initial begin
		do_reset();
		t_defaults();
		t_local();
		t_global();
		t_port();
		t_soft();
		host.wr(ADDR_POWER, 8'h02);
		do_reset();
		chk("power_mode", 8'h00, {6'h00, power_mode});
		finish_test();
	end
endmodule // testbench
